/* File: rtl/wmc_pkg.sv */
/*
 Package for the wake-up measure/compare unit: register indices, field
 positions, reset values, the weight shift base and sequencer states.
 Assumes a 32-bit APB bus where each register index takes one aligned word.
*/
`default_nettype none
package wmc_pkg;
	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_AMP_REF = 8'h34;
	localparam logic [7:0] IDX_AMP_AVG = 8'h35;
	localparam logic [7:0] IDX_AMP_RES = 8'h36;
	localparam logic [7:0] IDX_PH_CFG = 8'h37;
	localparam logic [7:0] IDX_PH_REF = 8'h38;
	localparam logic [7:0] IDX_PH_AVG = 8'h39;
	localparam logic [7:0] IDX_PH_RES = 8'h3A;
	localparam logic [7:0] IDX_CAP_CFG = 8'h3B;
	localparam logic [7:0] IDX_CAP_REF = 8'h3C;
	localparam logic [7:0] IDX_CAP_AVG = 8'h3D;
	localparam logic [7:0] IDX_CAP_RES = 8'h3E;
	// Own control/status words
	localparam logic [7:0] IDX_WAKE_CTRL = 8'h40;
	localparam logic [7:0] IDX_WAKE_STAT = 8'h41;
	// ==========================================================
	// Field positions
	localparam int CFG_THR_LSB = 4;
	localparam int CFG_INCL_BIT = 3;
	localparam int CFG_WGT_LSB = 1;
	localparam int CFG_REFSEL_BIT = 0;
	localparam int CTRL_PH_EN_BIT = 1;
	localparam int CTRL_CAP_EN_BIT = 0;
	localparam int STAT_PH_BIT = 1;
	localparam int STAT_CAP_BIT = 0;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_CTRL = 2'h0;
	// Weight code 00 means weight 4, i.e. a shift of two
	localparam logic [2:0] WGT_SHIFT_BASE = 3'h2;
	typedef enum logic [1:0] {WMC_IDLE, WMC_PHASE, WMC_CAP} wmc_state_t;
endpackage
`default_nettype wire

/* File: rtl/wmc_compare.sv */
/*
 Wake-up measure/compare unit: reference, auto-average and result
 registers for amplitude, phase and capacitance, thresholds for phase and
 capacitance only, and the phase and capacitance wake-up events.
 Assumes an APB master on pclk, a one-cycle timeout pulse from the wake-up
 timer, and measurement circuits answering with a valid pulse and a byte.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Amplitude reference byte, read/write, resets zero
// - Amplitude running average byte, read only
// - Latest amplitude result byte, read only
// - Phase threshold in upper four config bits
// - Phase config bit three includes triggering sample
// - Two-bit weight code: 4, 8, 16, 32
// - Phase bit zero: stored reference or average
// - Phase reference byte, read/write, resets zero
// - Phase running average byte, read only
// - Latest phase result byte, read only
// - Capacitance threshold in upper four config bits
// - Capacitance bit three includes triggering sample
// - Capacitance bit zero: stored reference or average
// - Capacitance reference byte, read/write, resets zero
// - Capacitance running average byte, read only
// - Latest capacitance result byte, read only
// - Phase measured each timeout that finds the sequencer idle, when enabled
// - Capacitance measured each timeout that finds the sequencer idle, when enabled
module wmc_compare
	import wmc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_timeout,
	input wire logic amp_result_valid,
	input wire logic [7:0] amp_result,
	input wire logic [7:0] amp_average,
	output logic phase_meas_start,
	input wire logic phase_result_valid,
	input wire logic [7:0] phase_result,
	output logic cap_meas_start,
	input wire logic cap_result_valid,
	input wire logic [7:0] cap_result,
	output logic phase_wake_event,
	output logic cap_wake_event
);
	import wmc_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
		abs_diff = (a >= b) ? (a - b) : (b - a);
	endfunction

	// Strict compare: a difference equal to the threshold does not wake
	function automatic logic over_limit(input logic [7:0] sample, input logic [7:0] ref_byte,
		input logic [3:0] limit);
		over_limit = abs_diff(sample, ref_byte) > {4'h0, limit};
	endfunction

	// Tripping samples only reach the average when the include bit is set
	function automatic logic take_sample(input logic done, input logic trip, input logic incl);
		take_sample = done && (!trip || incl);
	endfunction

	// Average plus signed difference shifted by 2..5, arithmetic shift keeps sign
	function automatic logic [7:0] next_average(input logic [7:0] avg, input logic [7:0] sample,
		input logic [1:0] wcode);
		logic signed [9:0] diff;
		logic signed [9:0] step;
		logic [2:0] sh;
		diff = $signed({2'h0, sample}) - $signed({2'h0, avg});
		sh = WGT_SHIFT_BASE + {1'h0, wcode};
		step = diff >>> sh;
		next_average = avg + step[7:0];
	endfunction

	// ==========================================================
	// Registers
	logic [7:0] amp_ref_value;
	logic [7:0] amp_avg_view;
	logic [7:0] amp_last_result;
	logic [7:0] phase_cfg;
	logic [7:0] phase_ref_value;
	logic [7:0] phase_running_avg;
	logic [7:0] phase_last_result;
	logic [7:0] cap_cfg;
	logic [7:0] cap_ref_value;
	logic [7:0] cap_running_avg;
	logic [7:0] cap_last_result;
	logic [1:0] wake_ctrl;
	logic [1:0] wake_stat;
	wmc_state_t state;
	wmc_state_t next_state;

	// ==========================================================
	// APB decode
	wire [7:0] reg_idx = paddr[9:2];
	wire addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
	wire access = psel && penable;
	wire wr_en = access && pwrite && addr_ok;
	wire rd_en = access && !pwrite && addr_ok;
	wire hit_stat = rd_en && (reg_idx == IDX_WAKE_STAT);
	logic [7:0] rd_byte;
	logic rd_known;

	always_comb
	begin
		rd_known = 1'h1;
		case (reg_idx)
			IDX_AMP_REF: rd_byte = amp_ref_value;
			IDX_AMP_AVG: rd_byte = amp_avg_view;
			IDX_AMP_RES: rd_byte = amp_last_result;
			IDX_PH_CFG: rd_byte = phase_cfg;
			IDX_PH_REF: rd_byte = phase_ref_value;
			IDX_PH_AVG: rd_byte = phase_running_avg;
			IDX_PH_RES: rd_byte = phase_last_result;
			IDX_CAP_CFG: rd_byte = cap_cfg;
			IDX_CAP_REF: rd_byte = cap_ref_value;
			IDX_CAP_AVG: rd_byte = cap_running_avg;
			IDX_CAP_RES: rd_byte = cap_last_result;
			IDX_WAKE_CTRL: rd_byte = {6'h00, wake_ctrl};
			IDX_WAKE_STAT: rd_byte = {6'h00, wake_stat};
			default:
			begin
				rd_byte = 8'h00;
				rd_known = 1'h0;
			end
		endcase
	end

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'h1;
	assign pslverr = access && (!addr_ok || !rd_known);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_byte};
	end

	// ==========================================================
	// Writable registers
	// Strobes decoded once so each register block stays a plain load
	wire wr_amp_ref = wr_en && (reg_idx == IDX_AMP_REF);
	wire wr_ph_cfg = wr_en && (reg_idx == IDX_PH_CFG);
	wire wr_ph_ref = wr_en && (reg_idx == IDX_PH_REF);
	wire wr_cap_cfg = wr_en && (reg_idx == IDX_CAP_CFG);
	wire wr_cap_ref = wr_en && (reg_idx == IDX_CAP_REF);
	wire wr_ctrl = wr_en && (reg_idx == IDX_WAKE_CTRL);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			amp_ref_value <= RST_BYTE;
		else if (wr_amp_ref)
			amp_ref_value <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_cfg <= RST_BYTE;
		else if (wr_ph_cfg)
			phase_cfg <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_ref_value <= RST_BYTE;
		else if (wr_ph_ref)
			phase_ref_value <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cap_cfg <= RST_BYTE;
		else if (wr_cap_cfg)
			cap_cfg <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cap_ref_value <= RST_BYTE;
		else if (wr_cap_ref)
			cap_ref_value <= pwdata[7:0];
	end

	// Measurement enables, written by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_ctrl <= RST_CTRL;
		else if (wr_ctrl)
			wake_ctrl <= pwdata[1:0];
	end

	// ==========================================================
	// Amplitude: reference only; result and average come from outside
	// amplitude views
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			amp_last_result <= RST_BYTE;
			amp_avg_view <= RST_BYTE;
		end
		else if (amp_result_valid)
		begin
			amp_last_result <= amp_result;
			amp_avg_view <= amp_average;
		end
	end

	// ==========================================================
	// Phase compare
	wire [3:0] phase_threshold = phase_cfg[CFG_THR_LSB +: 4];
	wire phase_avg_include_trigger = phase_cfg[CFG_INCL_BIT];
	wire [1:0] phase_avg_weight = phase_cfg[CFG_WGT_LSB +: 2];
	wire phase_ref_select = phase_cfg[CFG_REFSEL_BIT];
	wire [7:0] phase_cmp_ref = phase_ref_select ? phase_running_avg : phase_ref_value;
	wire phase_trip = over_limit(phase_result, phase_cmp_ref, phase_threshold);
	wire phase_done = phase_result_valid && (state == WMC_PHASE);
	// tripping sample included only if set
	wire phase_fold = take_sample(phase_done, phase_trip, phase_avg_include_trigger);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_last_result <= RST_BYTE;
			phase_running_avg <= RST_BYTE;
		end
		else
		begin
			if (phase_done)
				phase_last_result <= phase_result;
			if (phase_fold)
				phase_running_avg <= next_average(phase_running_avg, phase_result, phase_avg_weight);
		end
	end

	// ==========================================================
	// Capacitance compare
	wire [3:0] cap_threshold = cap_cfg[CFG_THR_LSB +: 4];
	wire cap_avg_include_trigger = cap_cfg[CFG_INCL_BIT];
	wire [1:0] cap_avg_weight = cap_cfg[CFG_WGT_LSB +: 2];
	wire cap_ref_select = cap_cfg[CFG_REFSEL_BIT];
	wire [7:0] cap_cmp_ref = cap_ref_select ? cap_running_avg : cap_ref_value;
	wire cap_trip = over_limit(cap_result, cap_cmp_ref, cap_threshold);
	wire cap_done = cap_result_valid && (state == WMC_CAP);
	// tripping sample included only if set
	wire cap_fold = take_sample(cap_done, cap_trip, cap_avg_include_trigger);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_last_result <= RST_BYTE;
			cap_running_avg <= RST_BYTE;
		end
		else
		begin
			if (cap_done)
				cap_last_result <= cap_result;
			if (cap_fold)
				cap_running_avg <= next_average(cap_running_avg, cap_result, cap_avg_weight);
		end
	end

	// ==========================================================
	// Sequencer: phase first, then capacitance, one at a time
	// Timeouts arriving mid-sequence are dropped; the timer is slow.
	wire ph_en = wake_ctrl[CTRL_PH_EN_BIT];
	wire cap_en = wake_ctrl[CTRL_CAP_EN_BIT];

	always_comb
	begin
		next_state = state;
		case (state)
			WMC_IDLE:
				if (timer_timeout && ph_en)
					next_state = WMC_PHASE;
				else if (timer_timeout && cap_en)
					next_state = WMC_CAP;
			WMC_PHASE:
				if (phase_result_valid)
					next_state = cap_en ? WMC_CAP : WMC_IDLE;
			WMC_CAP:
				if (cap_result_valid)
					next_state = WMC_IDLE;
			default: next_state = WMC_IDLE;
		endcase
	end

	wire next_ph_start = (state == WMC_IDLE) && timer_timeout && ph_en;
	wire next_cap_start = ((state == WMC_IDLE) && timer_timeout && !ph_en && cap_en)
		|| (phase_done && cap_en);

	// Sequencer state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= WMC_IDLE;
		else
			state <= next_state;
	end

	// Start pulses last one cycle; the measuring side must latch them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_meas_start <= 1'h0;
			cap_meas_start <= 1'h0;
		end
		else
		begin
			phase_meas_start <= next_ph_start;
			cap_meas_start <= next_cap_start;
		end
	end

	// Event pulses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_wake_event <= 1'h0;
			cap_wake_event <= 1'h0;
		end
		else
		begin
			phase_wake_event <= phase_done && phase_trip;
			cap_wake_event <= cap_done && cap_trip;
		end
	end

	// Sticky status, cleared by reading; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_stat <= RST_CTRL;
		else
		begin
			wake_stat[STAT_PH_BIT] <= (phase_done && phase_trip) || (wake_stat[STAT_PH_BIT] && !hit_stat);
			wake_stat[STAT_CAP_BIT] <= (cap_done && cap_trip) || (wake_stat[STAT_CAP_BIT] && !hit_stat);
		end
	end
endmodule
`default_nettype wire

/* File: test/wmc_compare_properties.sv */
/* Port-level checker for wmc_compare.
   Assumes it is bound to the top module; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module wmc_compare_properties
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer_timeout,
	input wire logic phase_result_valid,
	input wire logic cap_result_valid,
	input wire logic phase_meas_start,
	input wire logic cap_meas_start,
	input wire logic phase_wake_event,
	input wire logic cap_wake_event
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	// ==========================================
	// Bus
	ready_high_a: assert property (pready) else $error("pready low");
	byte_wide_a: assert property (prdata[31:8] == 24'h0) else $error("upper bits set");
	map_ok_a: assert property (acc && paddr >= 12'h0D0 && paddr <= 12'h0F8 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped word refused");
	unmapped_err_a: assert property (acc && paddr == 12'h000 |-> pslverr) else $error("unmapped accepted");
	// ==========================================
	// Sequencing, one-cycle pulses
	ph_start_cause_a: assert property (phase_meas_start |-> $past(timer_timeout)) else $error("stray phase start");
	ph_start_pulse_a: assert property (phase_meas_start |=> !phase_meas_start) else $error("long phase start");
	cap_start_cause_a: assert property (cap_meas_start |-> $past(phase_result_valid) || $past(timer_timeout))
		else $error("stray cap start");
	ph_event_cause_a: assert property (phase_wake_event |-> $past(phase_result_valid)) else $error("stray event");
	cap_event_cause_a: assert property (cap_wake_event |-> $past(cap_result_valid)) else $error("stray event");
	ph_event_pulse_a: assert property (phase_wake_event |=> !phase_wake_event [*2]) else $error("long event");
	cover property (phase_wake_event);
	cover property (cap_wake_event);
	cover property (acc && pslverr);
endmodule
`default_nettype wire

/* File: test/wmc_compare_tb.sv */
/* Self-checking bench for wmc_compare with an integer model.
   Assumes package and design are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module wmc_compare_tb;
	import wmc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, timer_timeout = 0, amp_result_valid = 0, phase_result_valid = 0, cap_result_valid = 0;
	logic [7:0] amp_result = 8'h00, amp_average = 8'h00, phase_result = 8'h00, cap_result = 8'h00;
	logic phase_meas_start, cap_meas_start, phase_wake_event, cap_wake_event;
	integer seed = 26290, fails = 0, check_count = 0, cyc = 0, i, j, k, v, tp, tc;
	logic [7:0] ph_val, cap_val;
	integer cfg [2], refv [2], avg [2] = '{0, 0};
	always #10 pclk = ~pclk;
	wmc_compare uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.timer_timeout, .amp_result_valid, .amp_result, .amp_average, .phase_meas_start, .phase_result_valid,
		.phase_result, .cap_meas_start, .cap_result_valid, .cap_result, .phase_wake_event, .cap_wake_event);
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			fails++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// ==========================================
	// APB master, waits on pready
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		integer u;
		u = $random(seed);
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {u[23:0], wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		if (k >= 50)
			chk(pready, 1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] want);
		apb(1'b0, idx, 8'h00);
		chk(rd, want);
	endtask
	// Trip test and average update; reference taken before the update
	function automatic logic [31:0] model(input integer m, input integer r);
		integer d;
		d = r - (cfg[m][0] ? avg[m] : refv[m]);
		if (d < 0)
			d = -d;
		model = d > (cfg[m] >> 4);
		if (!model[0] || cfg[m][3])
			avg[m] = (avg[m] + ((r - avg[m]) >>> (2 + cfg[m][2:1]))) & 255;
	endfunction
	task automatic meas(input logic [7:0] pr, input logic [7:0] cr);
		@(posedge pclk);
		timer_timeout <= 1'b1;
		@(posedge pclk);
		timer_timeout <= 1'b0;
		@(posedge pclk);
		chk(phase_meas_start, 1);
		repeat (pr[1:0]) @(posedge pclk);
		phase_result_valid <= 1'b1;
		phase_result <= pr;
		@(posedge pclk);
		phase_result_valid <= 1'b0;
		phase_result <= ~pr;
		@(posedge pclk);
		tp = model(0, pr);
		chk(phase_wake_event, tp);
		chk(cap_meas_start, 1);
		cap_result_valid <= 1'b1;
		cap_result <= cr;
		@(posedge pclk);
		cap_result_valid <= 1'b0;
		cap_result <= ~cr;
		@(posedge pclk);
		tc = model(1, cr);
		chk(cap_wake_event, tc);
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (i = IDX_AMP_REF; i <= IDX_CAP_RES; i++)
		begin
			v = $random(seed);
			rchk(i[7:0], 0);
			apb(1'b1, i[7:0], v[7:0]);
			rchk(i[7:0], i[7:0] inside {IDX_AMP_REF, IDX_PH_CFG, IDX_PH_REF, IDX_CAP_CFG, IDX_CAP_REF} ? v[7:0] : 0);
		end
		v = $random(seed);
		@(posedge pclk);
		amp_result_valid <= 1'b1;
		amp_result <= v[7:0];
		amp_average <= v[15:8];
		@(posedge pclk);
		amp_result_valid <= 1'b0;
		rchk(IDX_AMP_RES, v[7:0]);
		rchk(IDX_AMP_AVG, v[15:8]);
		apb(1'b0, 8'h00, 8'h00);
		chk(err, 1);
		$display("test registers done");
		apb(1'b1, IDX_WAKE_CTRL, 8'h03);
		rchk(IDX_WAKE_CTRL, 3);
		for (i = 0; i < 40; i++)
		begin
			for (j = 0; j < 2; j++)
			begin
				cfg[j] = $random(seed) & 255;
				refv[j] = $random(seed) & 255;
				apb(1'b1, j ? IDX_CAP_CFG : IDX_PH_CFG, cfg[j][7:0]);
				apb(1'b1, j ? IDX_CAP_REF : IDX_PH_REF, refv[j][7:0]);
			end
			v = $random(seed);
			ph_val = refv[0][7:0] + v[4:0] - 8'h10;
			cap_val = refv[1][7:0] + v[12:8] - 8'h10;
			meas(ph_val, cap_val);
			rchk(IDX_PH_RES, ph_val);
			rchk(IDX_PH_AVG, avg[0]);
			rchk(IDX_CAP_RES, cap_val);
			rchk(IDX_CAP_AVG, avg[1]);
			rchk(IDX_WAKE_STAT, {tp[0], tc[0]});
		end
		apb(1'b1, IDX_WAKE_CTRL, 8'h01);
		cap_val = refv[1][7:0] ^ 8'h2C;
		@(posedge pclk);
		timer_timeout <= 1'b1;
		@(posedge pclk);
		timer_timeout <= 1'b0;
		@(posedge pclk);
		chk(phase_meas_start, 0);
		chk(cap_meas_start, 1);
		cap_result_valid <= 1'b1;
		cap_result <= cap_val;
		@(posedge pclk);
		cap_result_valid <= 1'b0;
		@(posedge pclk);
		tc = model(1, cap_val);
		chk(cap_wake_event, tc);
		rchk(IDX_CAP_AVG, avg[1]);
		rchk(IDX_WAKE_STAT, tc[0]);
		$display("test measurements done");
		give_verdict();
	end
endmodule
bind wmc_compare wmc_compare_properties chk_i (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
	.pslverr, .timer_timeout, .phase_result_valid, .cap_result_valid, .phase_meas_start, .cap_meas_start,
	.phase_wake_event, .cap_wake_event);
`default_nettype wire
